// ---- inc/pwm_clock_prescaler_consts.svh ----
`ifndef PWM_CLOCK_PRESCALER_CONSTS_SVH
`define PWM_CLOCK_PRESCALER_CONSTS_SVH
`define OFS_CONTROL 12'h000
`define OFS_PRESCALE 12'h004
`define OFS_SCALE_A 12'h008
`define OFS_SCALE_B 12'h00C
`define OFS_ENABLES 12'h010
`define OFS_CLOCK_SEL 12'h014
`define OFS_STATUS 12'h018
`define FREEZE_BIT 0
`define PRE_A_LSB 0
`define PRE_B_LSB 4
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ---- inc/pwm_clock_prescaler_pkg.sv ----
package pwm_clock_prescaler_pkg;
  typedef struct packed {
    logic prescaled_a;
    logic prescaled_b;
    logic scaled_a;
    logic scaled_b;
  } tick_set_type;
  typedef enum logic [1:0] {
    bus_idle = 2'b00,
    bus_write_resp = 2'b01,
    bus_read_resp = 2'b10
  } bus_state_type;
endpackage

// ---- src/pwm_clock_prescaler.sv ----
`timescale 1ns/1ps
`include "pwm_clock_prescaler_consts.svh"
// clock front end: prescaled and scaled tick enables for eight channels
module pwm_clock_prescaler #(
  parameter int CHANNELS = 8,
  parameter int SCALE_WIDTH = 8
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_freeze,
  input wire logic [11:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [11:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [CHANNELS-1:0] o_channel_ticks,
  output logic [3:0] o_clock_ticks
);
  logic freeze_meta;
  logic freeze_sync;
  logic freeze_clock_stop;
  logic [2:0] prescale_a_select;
  logic [2:0] prescale_b_select;
  logic [SCALE_WIDTH-1:0] scale_a;
  logic [SCALE_WIDTH-1:0] scale_b;
  logic [CHANNELS-1:0] channel_enables;
  logic [CHANNELS-1:0] clock_sel;
  logic [6:0] prescale_count;
  logic run;
  logic [6:0] next_prescale_count;
  pwm_clock_prescaler_pkg::tick_set_type ticks;
  logic scaled_a_tick;
  logic scaled_b_tick;
  pwm_clock_prescaler_pkg::bus_state_type bus_state;
  pwm_clock_prescaler_pkg::bus_state_type next_bus_state;
  logic aw_held;
  logic w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic next_aw_held;
  logic next_w_held;
  logic [11:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic [1:0] next_bresp;
  logic [1:0] next_rresp;
  logic [31:0] next_rdata;
  logic next_freeze_clock_stop;
  logic [2:0] next_prescale_a_select;
  logic [2:0] next_prescale_b_select;
  logic [SCALE_WIDTH-1:0] next_scale_a;
  logic [SCALE_WIDTH-1:0] next_scale_b;
  logic [CHANNELS-1:0] next_channel_enables;
  logic [CHANNELS-1:0] next_clock_sel;
  logic [CHANNELS-1:0] next_channel_ticks;

  function automatic logic [31:0] byte_merge(input logic [31:0] old_value,
    input logic [31:0] new_value, input logic [3:0] strb);
    logic [31:0] result;
    result = old_value;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        result[i*8 +: 8] = new_value[i*8 +: 8];
      end
    end
    return result;
  endfunction

  // tick when the low bits of the free counter wrap for the chosen power of two
  function automatic logic rate_tick(input logic [6:0] count, input logic [2:0] sel);
    logic [6:0] mask;
    mask = 7'h7F >> (3'h7 - sel);
    return (count & mask) == mask;
  endfunction

  function automatic logic addr_known(input logic [11:0] addr);
    return addr == `OFS_CONTROL || addr == `OFS_PRESCALE || addr == `OFS_SCALE_A ||
      addr == `OFS_SCALE_B || addr == `OFS_ENABLES || addr == `OFS_CLOCK_SEL ||
      addr == `OFS_STATUS;
  endfunction

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      freeze_meta <= 1'b0;
      freeze_sync <= 1'b0;
    end
    else
    begin
      freeze_meta <= i_freeze;
      freeze_sync <= freeze_meta;
    end
  end

  // prescaler input gated by freeze while the control freeze bit is set, and by all channels off
  assign run = !(freeze_clock_stop && freeze_sync) && (channel_enables != '0);

  always_comb
  begin
    next_prescale_count = prescale_count;
    if (run)
    begin
      next_prescale_count = prescale_count + 7'h01;
    end
    ticks.prescaled_a = run && rate_tick(prescale_count, prescale_a_select);
    ticks.prescaled_b = run && rate_tick(prescale_count, prescale_b_select);
    ticks.scaled_a = scaled_a_tick;
    ticks.scaled_b = scaled_b_tick;
  end

  scale_divider #(.WIDTH(SCALE_WIDTH)) divider_a (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_tick(ticks.prescaled_a),
    .i_reload(scale_a),
    .o_tick(scaled_a_tick)
  );

  scale_divider #(.WIDTH(SCALE_WIDTH)) divider_b (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_tick(ticks.prescaled_b),
    .i_reload(scale_b),
    .o_tick(scaled_b_tick)
  );

  // channels 0,1,4,5 use the A family, 2,3,6,7 the B family
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++)
    begin : g_channel
      if (((ch / 2) % 2) == 0)
      begin : g_a
        assign next_channel_ticks[ch] = channel_enables[ch] &&
          (clock_sel[ch] ? ticks.scaled_a : ticks.prescaled_a);
      end
      else
      begin : g_b
        assign next_channel_ticks[ch] = channel_enables[ch] &&
          (clock_sel[ch] ? ticks.scaled_b : ticks.prescaled_b);
      end
    end
  endgenerate

  always_comb
  begin
    next_bus_state = bus_state;
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bresp = o_bresp;
    next_rresp = o_rresp;
    next_rdata = o_rdata;
    next_freeze_clock_stop = freeze_clock_stop;
    next_prescale_a_select = prescale_a_select;
    next_prescale_b_select = prescale_b_select;
    next_scale_a = scale_a;
    next_scale_b = scale_b;
    next_channel_enables = channel_enables;
    next_clock_sel = clock_sel;
    case (bus_state)
      pwm_clock_prescaler_pkg::bus_idle:
      begin
        if (i_awvalid && o_awready)
        begin
          next_aw_held = 1'b1;
          next_aw_addr = i_awaddr;
        end
        if (i_wvalid && o_wready)
        begin
          next_w_held = 1'b1;
          next_w_data = i_wdata;
          next_w_strb = i_wstrb;
        end
        if (aw_held && w_held)
        begin
          next_aw_held = 1'b0;
          next_w_held = 1'b0;
          next_bresp = addr_known(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
          next_bus_state = pwm_clock_prescaler_pkg::bus_write_resp;
          case (aw_addr)
            `OFS_CONTROL:
            begin
              if (w_strb[0])
              begin
                next_freeze_clock_stop = w_data[`FREEZE_BIT];
              end
            end
            `OFS_PRESCALE:
            begin
              if (w_strb[0])
              begin
                next_prescale_a_select = w_data[`PRE_A_LSB +: 3];
                next_prescale_b_select = w_data[`PRE_B_LSB +: 3];
              end
            end
            `OFS_SCALE_A:
            begin
              next_scale_a = SCALE_WIDTH'(byte_merge(32'(scale_a), w_data, w_strb));
            end
            `OFS_SCALE_B:
            begin
              next_scale_b = SCALE_WIDTH'(byte_merge(32'(scale_b), w_data, w_strb));
            end
            `OFS_ENABLES:
            begin
              next_channel_enables = CHANNELS'(byte_merge(32'(channel_enables), w_data,
                w_strb));
            end
            `OFS_CLOCK_SEL:
            begin
              next_clock_sel = CHANNELS'(byte_merge(32'(clock_sel), w_data, w_strb));
            end
            default:
            begin
              next_bresp = addr_known(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
            end
          endcase
        end
        else if (i_arvalid && o_arready && !aw_held && !w_held)
        begin
          next_bus_state = pwm_clock_prescaler_pkg::bus_read_resp;
          next_rresp = addr_known(i_araddr) ? `RESP_OKAY : `RESP_SLVERR;
          case (i_araddr)
            `OFS_CONTROL: next_rdata = {31'h0, freeze_clock_stop};
            `OFS_PRESCALE: next_rdata = {25'h0, prescale_b_select, 1'b0, prescale_a_select};
            `OFS_SCALE_A: next_rdata = {24'h0, scale_a};
            `OFS_SCALE_B: next_rdata = {24'h0, scale_b};
            `OFS_ENABLES: next_rdata = {24'h0, channel_enables};
            `OFS_CLOCK_SEL: next_rdata = {24'h0, clock_sel};
            `OFS_STATUS: next_rdata = {22'h0, freeze_sync, run, 1'b0, prescale_count};
            default: next_rdata = 32'h0;
          endcase
        end
      end
      pwm_clock_prescaler_pkg::bus_write_resp:
      begin
        if (i_bready)
        begin
          next_bus_state = pwm_clock_prescaler_pkg::bus_idle;
        end
      end
      pwm_clock_prescaler_pkg::bus_read_resp:
      begin
        if (i_rready)
        begin
          next_bus_state = pwm_clock_prescaler_pkg::bus_idle;
        end
      end
      default:
      begin
        next_bus_state = pwm_clock_prescaler_pkg::bus_idle;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      bus_state <= pwm_clock_prescaler_pkg::bus_idle;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_arready <= 1'b0;
      o_bvalid <= 1'b0;
      o_rvalid <= 1'b0;
      o_bresp <= `RESP_OKAY;
      o_rresp <= `RESP_OKAY;
      o_rdata <= 32'h0000_0000;
      freeze_clock_stop <= 1'b0;
      prescale_a_select <= 3'h0;
      prescale_b_select <= 3'h0;
      scale_a <= '0;
      scale_b <= '0;
      channel_enables <= '0;
      clock_sel <= '0;
      prescale_count <= 7'h00;
      o_channel_ticks <= '0;
      o_clock_ticks <= 4'h0;
    end
    else
    begin
      bus_state <= next_bus_state;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      o_awready <= (next_bus_state == pwm_clock_prescaler_pkg::bus_idle) && !next_aw_held;
      o_wready <= (next_bus_state == pwm_clock_prescaler_pkg::bus_idle) && !next_w_held;
      o_arready <= (next_bus_state == pwm_clock_prescaler_pkg::bus_idle) && !next_aw_held
        && !next_w_held && !o_arready;
      o_bvalid <= next_bus_state == pwm_clock_prescaler_pkg::bus_write_resp;
      o_rvalid <= next_bus_state == pwm_clock_prescaler_pkg::bus_read_resp;
      o_bresp <= next_bresp;
      o_rresp <= next_rresp;
      o_rdata <= next_rdata;
      freeze_clock_stop <= next_freeze_clock_stop;
      prescale_a_select <= next_prescale_a_select;
      prescale_b_select <= next_prescale_b_select;
      scale_a <= next_scale_a;
      scale_b <= next_scale_b;
      channel_enables <= next_channel_enables;
      clock_sel <= next_clock_sel;
      prescale_count <= next_prescale_count;
      o_channel_ticks <= next_channel_ticks;
      o_clock_ticks <= ticks;
    end
  end

  sequence frozen_s;
    freeze_clock_stop && freeze_sync;
  endsequence

  freeze_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    frozen_s |=> $stable(prescale_count))
    else $error("prescaler advanced while frozen");
  idle_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (channel_enables == '0) |=> o_clock_ticks[3:2] == 2'b00
      && $stable(prescale_count))
    else $error("prescaler advanced with all channels off");
  full_rate_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (run && prescale_a_select == 3'h0) |=> o_clock_ticks[3])
    else $error("divide by one did not tick every cycle");
  slow_rate_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (ticks.prescaled_b && prescale_b_select == 3'h7) |-> prescale_count == 7'h7F)
    else $error("divide by 128 ticked at wrong count");
  chan_off_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !channel_enables[0] |=> !o_channel_ticks[0])
    else $error("disabled channel ticked");
  chan_sel_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (channel_enables[0] && !clock_sel[0] && ticks.prescaled_a) |=> o_channel_ticks[0])
    else $error("channel missed its prescaled tick");
  scaled_src_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    scaled_a_tick |-> $past(ticks.prescaled_a))
    else $error("scaled tick without prescaled tick");
  resp_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (o_bvalid && !i_bready) |=> o_bvalid)
    else $error("write response dropped");
endmodule

// ---- src/scale_divider.sv ----
`timescale 1ns/1ps
// divides an input tick train by reload value then by two; zero reloads as 256
module scale_divider #(
  parameter int WIDTH = 8
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_tick,
  input wire logic [WIDTH-1:0] i_reload,
  output logic o_tick
);
  logic [WIDTH-1:0] count;
  logic half;
  logic [WIDTH-1:0] next_count;
  logic next_half;
  logic next_tick;

  always_comb
  begin
    next_count = count;
    next_half = half;
    next_tick = 1'b0;
    if (i_tick)
    begin
      // count wraps through zero, so a reload of zero gives 256 steps
      if (count == {{(WIDTH-1){1'b0}}, 1'b1})
      begin
        next_count = i_reload;
        next_half = ~half;
        next_tick = half;
      end
      else
      begin
        next_count = count - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      count <= {{(WIDTH-1){1'b0}}, 1'b1};
      half <= 1'b0;
      o_tick <= 1'b0;
    end
    else
    begin
      count <= next_count;
      half <= next_half;
      o_tick <= next_tick;
    end
  end

  load_tick_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_tick && count == {{(WIDTH-1){1'b0}}, 1'b1} && half) |=> o_tick)
    else $error("scaled tick missing after full period");
  no_tick_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !$past(i_tick) |-> !o_tick)
    else $error("scaled tick without input tick");
endmodule

// ---- test/tb_pwm_clock_prescaler.sv ----
`timescale 1ns/1ps
module tb_pwm_clock_prescaler;
  localparam int LIMIT = 60000;
  localparam int MASKS [7] = '{32'h1, 32'h77, 32'hFF, 32'hFF, 32'hFF, 32'hFF, 32'h0};
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_freeze = 1'b0;
  logic [11:0] i_awaddr = 12'h000;
  logic i_awvalid = 1'b0;
  logic [31:0] i_wdata = 32'h0;
  logic [3:0] i_wstrb = 4'h0;
  logic i_wvalid = 1'b0;
  logic i_bready = 1'b0;
  logic [11:0] i_araddr = 12'h000;
  logic i_arvalid = 1'b0;
  logic i_rready = 1'b0;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0] o_bresp, o_rresp;
  logic [31:0] o_rdata;
  logic [7:0] o_channel_ticks;
  logic [3:0] o_clock_ticks;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int seed = 87;
  int model [7] = '{0, 0, 0, 0, 0, 0, 0};
  int cnt [12];

  pwm_clock_prescaler dut (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_freeze(i_freeze),
    .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready),
    .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
    .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
    .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
    .o_channel_ticks(o_channel_ticks), .o_clock_ticks(o_clock_ticks)
  );

  always #2 i_clk = ~i_clk;

  task automatic complete_run();
    if (num_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge i_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      num_errors++;
      $display("CHECK FAILED %0t timeout", $time);
      complete_run();
    end
  end

  task automatic expect_eq(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // ready is a register, so its level at the falling edge is what the next edge samples
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    logic aw_done, w_done, aw_hit, w_hit;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge i_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_wstrb <= s;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(negedge i_clk);
      aw_hit = !aw_done && o_awready === 1'b1;
      w_hit = !w_done && o_wready === 1'b1;
      @(posedge i_clk);
      if (aw_hit)
        i_awvalid <= 1'b0;
      if (w_hit)
        i_wvalid <= 1'b0;
      aw_done = aw_done | aw_hit;
      w_done = w_done | w_hit;
    end
    i_bready <= 1'b1;
    do @(negedge i_clk); while (o_bvalid !== 1'b1);
    r = o_bresp;
    @(posedge i_clk);
    i_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge i_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    do @(negedge i_clk); while (o_arready !== 1'b1);
    @(posedge i_clk);
    i_arvalid <= 1'b0;
    i_rready <= 1'b1;
    do @(negedge i_clk); while (o_rvalid !== 1'b1);
    d = o_rdata;
    r = o_rresp;
    @(posedge i_clk);
    i_rready <= 1'b0;
  endtask

  task automatic reg_write(input int idx, input int d);
    logic [1:0] r;
    logic [31:0] q;
    axi_write(12'(idx * 4), d, 4'hF, r);
    expect_eq({30'h0, r}, 32'h0);
    model[idx] = d & MASKS[idx];
    axi_read(12'(idx * 4), q, r);
    expect_eq(q, model[idx]);
  endtask

  // the last of three gaps is taken so a config change mid-count does not matter
  task automatic period(input int idx, input int exp);
    int n;
    for (int k = 0; k < 3; k++)
    begin
      n = 0;
      do
      begin
        @(negedge i_clk);
        n++;
      end
      while (o_clock_ticks[idx] !== 1'b1);
    end
    expect_eq(n, exp);
  endtask

  task automatic count_ticks(input int w, output int c [12]);
    logic [11:0] v;
    for (int i = 0; i < 12; i++)
      c[i] = 0;
    repeat (w)
    begin
      @(negedge i_clk);
      v = {o_channel_ticks, o_clock_ticks};
      for (int i = 0; i < 12; i++)
        c[i] += int'(v[i] === 1'b1);
    end
  endtask

  function automatic logic near(input int got, input int p, input int w);
    return got * p >= w - p && got * p <= w + p;
  endfunction

  initial
  begin
    logic [31:0] q, q2;
    logic [1:0] r;
    int sel, rl, csel, idx;
    int p [4];
    repeat (3) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (2) @(posedge i_clk);
    axi_read(12'h018, q, r);
    expect_eq(q[9:8], 32'h0);
    reg_write(4, 32'hFF);
    for (sel = 0; sel < 8; sel++)
    begin
      reg_write(1, (7 - sel) << 4 | sel);
      period(3, 1 << sel);
      period(2, 1 << (7 - sel));
    end
    reg_write(1, 32'h10);
    reg_write(2, 32'h1);
    reg_write(3, 32'h0);
    period(1, 2);
    period(0, 1024);
    reg_write(2, 32'h0);
    reg_write(3, 32'hFF);
    period(1, 512);
    period(0, 1020);
    repeat (3)
    begin
      sel = $random(seed) & 3;
      rl = ($random(seed) & 63) + 1;
      reg_write(1, sel << 4 | sel);
      reg_write(2, rl);
      reg_write(3, rl + 1);
      period(1, (2 * rl) << sel);
      period(0, (2 * (rl + 1)) << sel);
    end
    axi_write(12'h008, 32'h55, 4'h0, r);
    axi_read(12'h008, q, r);
    expect_eq(q, model[2]);
    axi_write(12'h01C, 32'hFF, 4'hF, r);
    expect_eq({30'h0, r}, 32'h2);
    axi_read(12'h01C, q, r);
    expect_eq({q[29:0], r}, 32'h2);
    reg_write(1, 32'h21);
    reg_write(2, 2);
    reg_write(3, 3);
    p = '{24, 8, 4, 2};
    csel = $random(seed) & 255;
    for (int k = 0; k < 2; k++)
    begin
      reg_write(5, k == 1 ? ~csel & 255 : csel);
      repeat (300) @(posedge i_clk);
      count_ticks(1200, cnt);
      for (int i = 0; i < 4; i++)
        expect_eq(near(cnt[i], p[i], 1200), 1);
      for (int ch = 0; ch < 8; ch++)
      begin
        idx = (model[5] >> ch) & 1;
        idx = (ch & 2) == 0 ? 3 - 2 * idx : 2 - 2 * idx;
        expect_eq(near(cnt[4 + ch], p[idx], 1200), 1);
      end
    end
    reg_write(0, 1);
    i_freeze <= 1'b1;
    repeat (8) @(posedge i_clk);
    count_ticks(200, cnt);
    for (int i = 0; i < 12; i++)
      expect_eq(cnt[i], 0);
    axi_read(12'h018, q, r);
    expect_eq(q[9:8], 32'h2);
    reg_write(0, 0);
    period(3, 2);
    i_freeze <= 1'b0;
    reg_write(4, 0);
    repeat (8) @(posedge i_clk);
    count_ticks(200, cnt);
    for (int i = 0; i < 12; i++)
      expect_eq(cnt[i], 0);
    axi_read(12'h018, q, r);
    axi_read(12'h018, q2, r);
    expect_eq({q[8], q[6:0]}, {1'b0, q2[6:0]});
    reg_write(4, 32'h01);
    period(3, 2);
    complete_run();
  end
endmodule
